// ### verilog/arsc_ctrl.sv
// Reset and power-down control for a single-channel delta-sigma front end.
// Assumes the host drives the serial framing and the clear pin synchronously.
`timescale 1ns/10ps
module arsc_ctrl
#(
  parameter int BIAS_CYCLES = arsc_pkg::BIAS_SETTLE_CYCLES
)
(
  // Clock and power-on reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Host pins and mode
  input wire logic i_hard_clear_n,
  input wire logic i_two_wire_mode,
  input wire logic i_watchdog_reset,
  input wire logic i_spi_cs_n,
  // Register writes decoded by the serial port
  input wire logic i_cfg_we,
  input wire logic [1:0] i_power_down,
  input wire logic i_external_reference_select,
  input wire logic i_external_clock_select,
  input wire logic [11:0] i_phase_delay,
  input wire logic [7:0] i_osr_cfg,
  // Conversion path
  input wire logic i_sample_valid,
  input wire logic [23:0] i_sample,
  input wire logic [3:0] i_cmp_raw,
  // Outputs
  output logic o_hard_reset,
  output logic o_spi_reset,
  output logic o_spi_idle,
  output logic o_data_ready,
  output logic [23:0] o_data,
  output logic [3:0] o_cmp,
  output logic [11:0] o_phase_delay,
  output logic [7:0] o_osr_cfg,
  output logic [1:0] o_power_down,
  output logic o_external_reference_select,
  output logic o_external_clock_select,
  output logic o_core_clk_en,
  output logic o_bias_en,
  output logic o_vref_en,
  output logic o_supply_mon_en,
  output logic o_bias_settled
);
  // ***************************************************************
  // Hard reset qualification
  // ***************************************************************
  logic hard_rst;
  assign hard_rst = (!i_two_wire_mode && !i_hard_clear_n) // R1 R3
                    || (i_two_wire_mode && i_watchdog_reset); // R3
  assign o_hard_reset = hard_rst;
  // ***************************************************************
  // Configuration registers
  // ***************************************************************
  logic [1:0] pd;
  logic vref_ext;
  logic clk_ext;
  logic [11:0] phase;
  logic [7:0] osr;
  logic [1:0] next_pd;
  logic next_vref_ext;
  logic next_clk_ext;
  logic [11:0] next_phase;
  logic [7:0] next_osr;
  always_comb
  begin
    next_pd = pd;
    next_vref_ext = vref_ext;
    next_clk_ext = clk_ext;
    next_phase = phase;
    next_osr = osr;
    if (hard_rst)
    begin
      next_pd = arsc_pkg::PD_RESET; // R2
      next_vref_ext = 1'b0;
      next_clk_ext = 1'b0;
      next_phase = arsc_pkg::PHASE_RESET;
      next_osr = arsc_pkg::OSR_RESET;
    end
    else if (i_cfg_we)
    begin
      // Power-down only writable in SPI mode.
      if (!i_two_wire_mode)
      begin
        next_pd = i_power_down; // R8 R13
      end
      next_vref_ext = i_external_reference_select;
      next_clk_ext = i_external_clock_select;
      next_phase = i_phase_delay; // R10
      next_osr = i_osr_cfg;
    end
  end
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pd <= arsc_pkg::PD_RESET; // R2
      vref_ext <= 1'b0;
      clk_ext <= 1'b0;
      phase <= arsc_pkg::PHASE_RESET;
      osr <= arsc_pkg::OSR_RESET;
    end
    else
    begin
      pd <= next_pd;
      vref_ext <= next_vref_ext;
      clk_ext <= next_clk_ext;
      phase <= next_phase;
      osr <= next_osr;
    end
  end
  assign o_power_down = pd;
  assign o_external_reference_select = vref_ext;
  assign o_external_clock_select = clk_ext;
  assign o_phase_delay = phase; // R10
  assign o_osr_cfg = osr;
  // ***************************************************************
  // Power state
  // ***************************************************************
  arsc_pkg::arsc_pwr_t pwr;
  arsc_pkg::arsc_pwr_t next_pwr;
  always_comb
  begin
    if (pd[0] && vref_ext && clk_ext)
    begin
      // Full shutdown is only entered from SPI mode. Once in it, a later mode
      // change does not wake the reference, so only clearing a bit, by a write or a hard reset, can leave it.
      if (!i_two_wire_mode || (pwr == arsc_pkg::ARSC_FULL_OFF))
      begin
        next_pwr = arsc_pkg::ARSC_FULL_OFF; // R12 R13
      end
      else
      begin
        next_pwr = arsc_pkg::ARSC_ADC_OFF; // R13
      end
    end
    else if (pd != 2'h0)
    begin
      next_pwr = arsc_pkg::ARSC_ADC_OFF; // R8
    end
    else
    begin
      next_pwr = arsc_pkg::ARSC_RUN; // R6
    end
  end
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pwr <= arsc_pkg::ARSC_RUN;
    end
    else
    begin
      pwr <= next_pwr;
    end
  end
  logic running;
  assign running = (pwr == arsc_pkg::ARSC_RUN);
  assign o_core_clk_en = running; // R11
  assign o_bias_en = running; // R6
  assign o_vref_en = (pwr != arsc_pkg::ARSC_FULL_OFF); // R12
  assign o_supply_mon_en = (pwr != arsc_pkg::ARSC_FULL_OFF); // R15 R14
  // ***************************************************************
  // Settling counters
  // ***************************************************************
  // Filter settling gates the ready strobe; the bias counter only informs
  // the host, which decides whether to discard early samples.
  logic [4:0] settle_cnt;
  logic [4:0] next_settle_cnt;
  logic [arsc_pkg::CNT_W-1:0] bias_cnt;
  logic [arsc_pkg::CNT_W-1:0] next_bias_cnt;
  logic settled;
  assign settled = (settle_cnt == 5'(arsc_pkg::SETTLE_CYCLES));
  always_comb
  begin
    next_settle_cnt = settle_cnt;
    next_bias_cnt = bias_cnt;
    if (!running || hard_rst)
    begin
      next_settle_cnt = 5'h00; // R6
      next_bias_cnt = '0;
    end
    else
    begin
      if (i_sample_valid && !settled)
      begin
        next_settle_cnt = settle_cnt + 5'h01;
      end
      if (bias_cnt != arsc_pkg::CNT_W'(BIAS_CYCLES))
      begin
        next_bias_cnt = bias_cnt + 1'b1; // R7
      end
    end
  end
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      settle_cnt <= 5'h00;
      bias_cnt <= '0;
    end
    else
    begin
      settle_cnt <= next_settle_cnt;
      bias_cnt <= next_bias_cnt;
    end
  end
  assign o_bias_settled = (bias_cnt == arsc_pkg::CNT_W'(BIAS_CYCLES)) && settled; // R7
  // ***************************************************************
  // Conversion output and buffers
  // ***************************************************************
  logic [23:0] buf_a;
  logic [23:0] buf_b;
  logic [3:0] cmp;
  logic drdy;
  logic [23:0] next_buf_a;
  logic [23:0] next_buf_b;
  logic [3:0] next_cmp;
  logic next_drdy;
  always_comb
  begin
    next_buf_a = buf_a;
    next_buf_b = buf_b;
    next_cmp = i_cmp_raw;
    next_drdy = 1'b0;
    if (hard_rst)
    begin
      next_buf_a = arsc_pkg::DATA_RESET; // R4
      next_buf_b = arsc_pkg::DATA_RESET; // R4
      next_cmp = arsc_pkg::CMP_RESET; // R4
    end
    else if (!running)
    begin
      next_buf_a = arsc_pkg::DATA_RESET; // R9
      next_buf_b = arsc_pkg::DATA_RESET; // R9
      next_cmp = arsc_pkg::CMP_RESET;
    end
    else if (i_sample_valid)
    begin
      next_buf_a = i_sample;
      next_buf_b = buf_a;
      next_drdy = settled; // R6 R9
    end
  end
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      buf_a <= arsc_pkg::DATA_RESET;
      buf_b <= arsc_pkg::DATA_RESET;
      cmp <= arsc_pkg::CMP_RESET;
      drdy <= 1'b0;
    end
    else
    begin
      buf_a <= next_buf_a;
      buf_b <= next_buf_b;
      cmp <= next_cmp;
      drdy <= next_drdy;
    end
  end
  assign o_data = buf_a;
  assign o_cmp = cmp;
  assign o_data_ready = drdy;
  // ***************************************************************
  // Serial interface reset state
  // ***************************************************************
  arsc_pkg::arsc_spi_t spi;
  arsc_pkg::arsc_spi_t next_spi;
  always_comb
  begin
    next_spi = spi;
    if (hard_rst)
    begin
      next_spi = arsc_pkg::ARSC_SPI_RESET; // R5
    end
    else
    begin
      unique case (spi)
        arsc_pkg::ARSC_SPI_RESET: next_spi = arsc_pkg::ARSC_SPI_IDLE; // R16
        arsc_pkg::ARSC_SPI_IDLE: next_spi = i_spi_cs_n ? spi : arsc_pkg::ARSC_SPI_BUSY;
        arsc_pkg::ARSC_SPI_BUSY: next_spi = i_spi_cs_n ? arsc_pkg::ARSC_SPI_IDLE : spi; // R14
        default: next_spi = arsc_pkg::ARSC_SPI_RESET;
      endcase
    end
  end
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      spi <= arsc_pkg::ARSC_SPI_RESET;
    end
    else
    begin
      spi <= next_spi;
    end
  end
  assign o_spi_reset = (spi == arsc_pkg::ARSC_SPI_RESET) || hard_rst; // R5
  assign o_spi_idle = (spi == arsc_pkg::ARSC_SPI_IDLE) && !hard_rst; // R16
endmodule

// ### verilog/arsc_pkg.sv
// Constants for the front-end reset and shutdown controller.
// Assumes a single 200 MHz core clock and plain control ports, no register bus.
// How it works
// R1: Hard reset only at power-on, while clear pin low in SPI mode, or on watchdog reset in two-wire mode.
// R2: Hard reset returns every internal register to its default value.
// R3: Two-wire mode ignores the clear pin; only watchdog reset fully resets.
// R4: Hard reset clears data, forces comparators to 0011, resets filter and buffers.
// R5: Serial interface held in reset during hard reset; host must not talk.
// R6: Clearing power-down re-enables bias, clock, logic; ready after filter settling.
// R7: Host should discard ready samples within 1 ms plus settling after shutdown.
// R8: ADC shutdown only in SPI mode via power-down field; configuration kept.
// R9: During ADC shutdown output data is zero and no ready pulses occur.
// R10: Phase delay setting before shutdown persists after leaving it.
// R11: Shutdown gates clock to input and core; restored automatically on resume.
// R12: Power-down bit 0 plus both external selects gives full shutdown.
// R13: Full shutdown may be entered only in SPI mode.
// R14: In full shutdown only the SPI interface stays active.
// R15: Any of those three bits back at zero re-enables both supply monitors.
// R16: On hard reset release the serial interface starts idle, awaiting chip select.
package arsc_pkg;
  // ***************************************************************
  // Widths and reset values
  // ***************************************************************
  localparam int DATA_W = 24;
  localparam int PHASE_W = 12;
  localparam int CMP_W = 4;
  localparam logic [3:0] CMP_RESET = 4'h3;
  localparam logic [23:0] DATA_RESET = 24'h000000;
  localparam logic [1:0] PD_RESET = 2'h0;
  localparam logic [11:0] PHASE_RESET = 12'h000;
  localparam logic [7:0] OSR_RESET = 8'h00;
  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_MHZ = 200;
  localparam int SETTLE_CYCLES = 16;
  localparam int BIAS_SETTLE_US = 1000;
  localparam int BIAS_SETTLE_CYCLES = BIAS_SETTLE_US * CLK_MHZ;
  localparam int CNT_W = 18;
  typedef enum logic [1:0] {ARSC_RUN, ARSC_ADC_OFF, ARSC_FULL_OFF} arsc_pwr_t;
  typedef enum logic [1:0] {ARSC_SPI_RESET, ARSC_SPI_IDLE, ARSC_SPI_BUSY} arsc_spi_t;
endpackage

// ### testbench/arsc_ctrl_checker.sv
// Port-level checks of the reset and shutdown controller.
// Bound onto arsc_ctrl by the bench; sees only that module's ports.
`timescale 1ns/10ps
module arsc_ctrl_checker
(
  // Watched ports
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_hard_clear_n,
  input wire logic i_two_wire_mode,
  input wire logic i_watchdog_reset,
  input wire logic i_cfg_we,
  input wire logic o_hard_reset,
  input wire logic o_spi_reset,
  input wire logic o_spi_idle,
  input wire logic o_data_ready,
  input wire logic [23:0] o_data,
  input wire logic [3:0] o_cmp,
  input wire logic [1:0] o_power_down,
  input wire logic o_external_reference_select,
  input wire logic o_external_clock_select,
  input wire logic o_core_clk_en,
  input wire logic o_vref_en,
  input wire logic o_supply_mon_en
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  // All three bits are needed, so clearing any one of them must wake the monitors.
  logic full;
  assign full = o_power_down[0] & o_external_reference_select & o_external_clock_select;
  property p_hr; o_hard_reset == (i_two_wire_mode ? i_watchdog_reset : !i_hard_clear_n);
  endproperty
  a_hr: assert property (p_hr) else $error("hard reset qualifier wrong");
  property p_spi; o_hard_reset |=> o_spi_reset; endproperty
  a_spi: assert property (p_spi) else $error("serial port not held");
  property p_clr; o_hard_reset |=> o_data == 0 && o_cmp == 4'h3 && o_power_down == 2'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("hard reset did not clear");
  property p_quiet; o_power_down != 0 && $past(o_power_down) != 0 && $past(o_power_down, 2) != 0
    |-> !o_data_ready && o_data == 0; endproperty
  a_quiet: assert property (p_quiet) else $error("output active in shutdown");
  property p_gate; o_power_down != 0 && !o_hard_reset |=> !o_core_clk_en; endproperty
  a_gate: assert property (p_gate) else $error("clock not gated");
  property p_full; full && !o_hard_reset && !i_two_wire_mode |=> !o_vref_en && !o_supply_mon_en;
  endproperty
  a_full: assert property (p_full) else $error("full shutdown not entered");
  property p_mon; !full |=> o_supply_mon_en; endproperty
  a_mon: assert property (p_mon) else $error("monitors stay off");
  property p_tw; i_two_wire_mode && i_cfg_we && !o_hard_reset |=> $stable(o_power_down);
  endproperty
  a_tw: assert property (p_tw) else $error("power down written in two-wire mode");
  property p_idle; $fell(o_hard_reset) |-> ##[1:2] o_spi_idle; endproperty
  a_idle: assert property (p_idle) else $error("port not idle after release");
endmodule

// ### testbench/arsc_host.sv
// Host model: frames chip select and screens data-ready samples.
// Assumes the controller's hard reset and ready outputs.
`timescale 1ns/10ps
module arsc_host
(
  // Controller side
  input wire logic i_core_clk,
  input wire logic i_hard_reset,
  input wire logic i_data_ready,
  input wire logic i_bias_settled,
  // Bench side
  input wire logic i_frame,
  output logic o_spi_cs_n = 1'b1,
  output logic o_sample_kept = 1'b0
);
  always_ff @(posedge i_core_clk)
  begin
    o_spi_cs_n <= !(i_frame && !i_hard_reset);
    o_sample_kept <= i_data_ready && i_bias_settled;
  end
endmodule

// ### testbench/arsc_ctrl_bench.sv
// Self-checking bench for the reset and shutdown controller.
// Drives the plain control ports; the host model frames chip select.
`timescale 1ns/10ps
module arsc_ctrl_bench;
  logic i_core_clk = 1'b0, i_rst = 1'b1, i_hard_clear_n = 1'b1, i_two_wire_mode = 1'b0;
  logic i_watchdog_reset = 1'b0, i_cfg_we = 1'b0, i_sample_valid = 1'b0, i_spi_cs_n, frame = 1'b0;
  logic i_external_reference_select = 1'b0, i_external_clock_select = 1'b0;
  logic [1:0] i_power_down = 2'h0, o_power_down;
  logic [11:0] i_phase_delay = 12'h000, o_phase_delay;
  logic [7:0] i_osr_cfg = 8'h3C, o_osr_cfg;
  logic [23:0] i_sample = 24'h000000, o_data;
  logic [3:0] i_cmp_raw = 4'hC, o_cmp;
  logic o_hard_reset, o_spi_reset, o_spi_idle, o_data_ready, o_core_clk_en, o_bias_en, kept;
  logic o_vref_en, o_supply_mon_en, o_bias_settled;
  logic o_external_reference_select, o_external_clock_select;
  int mismatches = 0, num_checks = 0, rdy, kcnt;
  arsc_ctrl #(.BIAS_CYCLES(25)) dut (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_hard_clear_n(i_hard_clear_n), .i_two_wire_mode(i_two_wire_mode),
    .i_watchdog_reset(i_watchdog_reset), .i_spi_cs_n(i_spi_cs_n), .i_cfg_we(i_cfg_we),
    .i_power_down(i_power_down), .i_external_reference_select(i_external_reference_select),
    .i_external_clock_select(i_external_clock_select), .i_phase_delay(i_phase_delay),
    .i_osr_cfg(i_osr_cfg), .i_sample_valid(i_sample_valid), .i_sample(i_sample),
    .i_cmp_raw(i_cmp_raw), .o_hard_reset(o_hard_reset), .o_spi_reset(o_spi_reset),
    .o_spi_idle(o_spi_idle), .o_data_ready(o_data_ready), .o_data(o_data), .o_cmp(o_cmp),
    .o_phase_delay(o_phase_delay), .o_osr_cfg(o_osr_cfg), .o_power_down(o_power_down),
    .o_external_reference_select(o_external_reference_select),
    .o_external_clock_select(o_external_clock_select), .o_core_clk_en(o_core_clk_en),
    .o_bias_en(o_bias_en), .o_vref_en(o_vref_en), .o_supply_mon_en(o_supply_mon_en),
    .o_bias_settled(o_bias_settled));
  arsc_host host (.i_core_clk(i_core_clk), .i_hard_reset(o_hard_reset),
    .i_data_ready(o_data_ready), .i_bias_settled(o_bias_settled), .i_frame(frame),
    .o_spi_cs_n(i_spi_cs_n), .o_sample_kept(kept));
  initial forever #2.5 i_core_clk = ~i_core_clk;
  task automatic chk(input logic ok, input string what);
    num_checks++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cfg(input logic [1:0] pd, input logic er, input logic ec, input logic [11:0] ph);
    @(posedge i_core_clk);
    i_cfg_we <= 1'b1;
    i_power_down <= pd;
    i_external_reference_select <= er;
    i_external_clock_select <= ec;
    i_phase_delay <= ph;
    @(posedge i_core_clk);
    i_cfg_we <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    #1;
  endtask
  // Counts ready pulses for a few cycles past the last sample, since the pulse lags it.
  task automatic feed(input int n);
    rdy = 0;
    kcnt = 0;
    repeat (n + 4)
    begin
      @(posedge i_core_clk);
      i_sample_valid <= n > 0;
      if (n > 0)
        i_sample <= i_sample + 24'h000101;
      n--;
      #1;
      rdy += int'(o_data_ready === 1'b1);
      kcnt += int'(kept === 1'b1);
    end
  endtask
  initial
  begin
    #50000;
    mismatches++;
    end_of_test();
  end
  initial
  begin
    repeat (20) @(posedge i_core_clk);
    #1;
    chk(o_data === 24'h000000 && o_cmp === 4'h3 && o_phase_delay === 12'h000, "por");
    chk(o_spi_reset === 1'b1 && o_power_down === 2'h0, "por port");
    @(posedge i_core_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    #1;
    chk(o_spi_idle === 1'b1, "idle");
    cfg(2'h0, 1'b0, 1'b0, 12'h5A5);
    feed(20);
    chk(rdy == 20 - arsc_pkg::SETTLE_CYCLES && o_data === 24'h001414, "run");
    chk(o_cmp === 4'hC, "run cmp");
    cfg(2'h1, 1'b0, 1'b0, 12'h5A5);
    chk(o_core_clk_en === 1'b0 && o_bias_en === 1'b0 && o_cmp === 4'h3, "gate");
    feed(20);
    chk(rdy == 0 && o_data === 24'h000000 && o_osr_cfg === 8'h3C, "off");
    cfg(2'h0, 1'b0, 1'b0, 12'h5A5);
    chk(o_core_clk_en === 1'b1 && o_bias_settled === 1'b0, "wake");
    feed(40);
    chk(rdy == 40 - arsc_pkg::SETTLE_CYCLES && o_bias_settled === 1'b1, "settle");
    chk(kcnt > 0 && kcnt < rdy && o_phase_delay === 12'h5A5, "kept");
    cfg(2'h1, 1'b1, 1'b1, 12'h5A5);
    chk(o_vref_en === 1'b0 && o_supply_mon_en === 1'b0, "full");
    @(posedge i_core_clk);
    frame <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    #1;
    chk(o_spi_reset === 1'b0 && i_spi_cs_n === 1'b0, "port live");
    cfg(2'h1, 1'b1, 1'b0, 12'h5A5);
    chk(o_supply_mon_en === 1'b1 && o_vref_en === 1'b1, "mon");
    @(posedge i_core_clk);
    i_hard_clear_n <= 1'b0;
    cfg(2'h2, 1'b0, 1'b0, 12'h0FF);
    chk(o_hard_reset === 1'b1 && o_spi_reset === 1'b1 && o_power_down === 2'h0, "hard");
    chk(o_phase_delay === 12'h000 && o_data === 24'h000000 && o_cmp === 4'h3, "clear");
    @(posedge i_core_clk);
    i_hard_clear_n <= 1'b1;
    frame <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    #1;
    chk(o_spi_idle === 1'b1, "idle again");
    @(posedge i_core_clk);
    i_two_wire_mode <= 1'b1;
    i_hard_clear_n <= 1'b0;
    cfg(2'h1, 1'b1, 1'b1, 12'h123);
    chk(o_hard_reset === 1'b0 && o_power_down === 2'h0 && o_vref_en === 1'b1, "two wire");
    chk(o_phase_delay === 12'h123, "two wire phase");
    @(posedge i_core_clk);
    i_watchdog_reset <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    #1;
    chk(o_hard_reset === 1'b1 && o_phase_delay === 12'h000, "watchdog");
    end_of_test();
  end
endmodule
bind arsc_ctrl arsc_ctrl_checker chk (.i_core_clk(i_core_clk), .i_rst(i_rst),
  .i_hard_clear_n(i_hard_clear_n), .i_two_wire_mode(i_two_wire_mode),
  .i_watchdog_reset(i_watchdog_reset), .i_cfg_we(i_cfg_we), .o_hard_reset(o_hard_reset),
  .o_spi_reset(o_spi_reset), .o_spi_idle(o_spi_idle), .o_data_ready(o_data_ready),
  .o_data(o_data), .o_cmp(o_cmp), .o_power_down(o_power_down),
  .o_external_reference_select(o_external_reference_select),
  .o_external_clock_select(o_external_clock_select), .o_core_clk_en(o_core_clk_en),
  .o_vref_en(o_vref_en), .o_supply_mon_en(o_supply_mon_en));
